// ### design/txq_pkg.sv
// constants, types and register map of the transmit queue control block
// assumes a 16-bit register port and a protocol engine on the same clock
//
// Summary of operation
// - base address low two bits read zero
// - base low register holds base address bits
// - payload code selects 8 to 64 bytes
// - depth equals depth code plus one
// - payload and depth writable only in configuration
// - attempts code: none, three, or unlimited
// - priority field passed to transmit selection
// - queue reset bit self-clears after reset
// - send request clears after queue drains
// - clearing set send request requests abort
// - increment bit advances head by one
// - enable gates attempts exhausted interrupt
// - separate enables for empty and not full
// - read-only index of next message
// - aborted bit updated on completion, abort, reset
// - lost arbitration bit set on arbitration loss
// - error bit set on bus error
// - exhausted flag set by hardware, software clears
// - empty flag reflects no queued message
// - not full flag reflects free slots
// - summary bit ORs enabled queue flags
// - global request bit mirrors send request
package txq_pkg;

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_BASE_LOW = 3'h0;
  localparam logic [2:0] ADDR_CONFIG_HIGH = 3'h1;
  localparam logic [2:0] ADDR_CONTROL_LOW = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_SUMMARY = 3'h4;
  localparam logic [2:0] ADDR_TX_REQUEST = 3'h5;
  localparam logic [2:0] ADDR_GLOBAL_CTRL = 3'h6;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POS_PAYLOAD_SIZE_SEL = 13;
  localparam int POS_DEPTH = 8;
  localparam int POS_RETRY = 5;
  localparam int POS_RESET = 10;
  localparam int POS_SEND = 9;
  localparam int POS_INC = 8;
  localparam int POS_AE = 4;
  localparam int POS_QE = 2;
  localparam int POS_NF = 0;
  localparam int POS_INDEX = 8;
  localparam int POS_ABORTED = 7;
  localparam int POS_ARB = 6;
  localparam int POS_BUSERR = 5;
  localparam int POS_RETRY_EN = 3;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [1:0] RETRY_RESET = 2'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [2:0] MODE_RESET = 3'h4;
  localparam logic [1:0] RETRY_NONE = 2'h0;
  localparam logic [1:0] RETRY_THREE = 2'h1;
  localparam logic [1:0] RETRY_UNLIMITED = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_FLUSH = 2'h2
  } state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic done;
    logic abort_done;
    logic arb_lost;
    logic bus_error;
    logic exhausted;
  } engine_evt_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic [4:0] index;
    logic [4:0] priority_lvl;
    logic [6:0] payload_bytes;
    logic [1:0] retry_mode;
    logic [15:0] base;
  } tx_ctrl_t;

endpackage

// ### design/can_fd_transmit_queue_control.sv
// transmit queue control and status, with the low message memory base
// assumes engine event pulses come from logic on clk_i, one cycle each
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module can_fd_transmit_queue_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire txq_pkg::bus_req_t bus_i,
  output logic [15:0] rdata_o,
  // protocol engine
  input wire txq_pkg::engine_evt_t evt_i,
  output txq_pkg::tx_ctrl_t ctrl_o,
  // interrupt request toward the global summary
  output logic irq_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    txq_pkg::state_t st;
    logic [13:0] base;
    logic [2:0] payload_size_sel;
    logic [4:0] depth_sel;
    logic [1:0] retry_sel;
    logic [4:0] prio;
    logic send_req;
    logic abort_req;
    logic ae_ie;
    logic qe_ie;
    logic nf_ie;
    logic [4:0] head;
    logic [4:0] tail;
    logic [5:0] count;
    logic aborted;
    logic arb_lost;
    logic bus_err;
    logic ae_flag;
    logic [2:0] mode;
    logic retry_en;
    logic [15:0] rdata;
    logic irq;
    txq_pkg::tx_ctrl_t ctrl;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // ------------------------------------------------------------
  // decoders
  // ------------------------------------------------------------
  function automatic logic [6:0] payload_bytes(input logic [2:0] sel);
    case (sel)
      3'h0: payload_bytes = 7'h08;
      3'h1: payload_bytes = 7'h0C;
      3'h2: payload_bytes = 7'h10;
      3'h3: payload_bytes = 7'h14;
      3'h4: payload_bytes = 7'h18;
      3'h5: payload_bytes = 7'h20;
      3'h6: payload_bytes = 7'h30;
      default: payload_bytes = 7'h40;
    endcase
  endfunction

  function automatic logic [5:0] depth_of(input logic [4:0] sel);
    depth_of = {1'b0, sel} + 6'h01;
  endfunction

  function automatic logic [4:0] wrap_inc(input logic [4:0] ptr, input logic [4:0] sel);
    if (ptr == sel)
    begin
      wrap_inc = 5'h00;
    end
    else
    begin
      wrap_inc = ptr + 5'h01;
    end
  endfunction

  function automatic logic [1:0] retry_mode(input logic en, input logic [1:0] sel);
    if (!en)
    begin
      retry_mode = txq_pkg::RETRY_UNLIMITED;
    end
    else if (sel == 2'h0)
    begin
      retry_mode = txq_pkg::RETRY_NONE;
    end
    else if (sel == 2'h1)
    begin
      retry_mode = txq_pkg::RETRY_THREE;
    end
    else
    begin
      retry_mode = txq_pkg::RETRY_UNLIMITED;
    end
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic wr_base;
  logic wr_conh;
  logic wr_conl;
  logic wr_sta;
  logic wr_treq;
  logic wr_glob;
  logic empty;
  logic not_full;
  logic do_inc;
  logic do_done;
  logic [15:0] rd_mux;

  always_comb
  begin
    next_r = r;
    wr_base = bus_i.wr && (bus_i.addr == txq_pkg::ADDR_BASE_LOW);
    wr_conh = bus_i.wr && (bus_i.addr == txq_pkg::ADDR_CONFIG_HIGH);
    wr_conl = bus_i.wr && (bus_i.addr == txq_pkg::ADDR_CONTROL_LOW);
    wr_sta = bus_i.wr && (bus_i.addr == txq_pkg::ADDR_STATUS);
    wr_treq = bus_i.wr && (bus_i.addr == txq_pkg::ADDR_TX_REQUEST);
    wr_glob = bus_i.wr && (bus_i.addr == txq_pkg::ADDR_GLOBAL_CTRL);
    empty = (r.count == 6'h00);
    not_full = (r.count < depth_of(r.depth_sel));
    do_inc = 1'b0;
    do_done = 1'b0;

    // configuration writes
    if (wr_base)
    begin
      next_r.base = bus_i.wdata[15:2];
    end
    if (wr_conh)
    begin
      // geometry may only change in configuration mode
      if (r.mode == txq_pkg::MODE_CONFIG)
      begin
        next_r.payload_size_sel = bus_i.wdata[txq_pkg::POS_PAYLOAD_SIZE_SEL +: 3];
        next_r.depth_sel = bus_i.wdata[txq_pkg::POS_DEPTH +: 5];
      end
      next_r.retry_sel = bus_i.wdata[txq_pkg::POS_RETRY +: 2];
      next_r.prio = bus_i.wdata[4:0];
    end
    if (wr_glob)
    begin
      next_r.mode = bus_i.wdata[2:0];
      next_r.retry_en = bus_i.wdata[txq_pkg::POS_RETRY_EN];
    end

    // control writes
    if (wr_conl)
    begin
      next_r.ae_ie = bus_i.wdata[txq_pkg::POS_AE];
      next_r.qe_ie = bus_i.wdata[txq_pkg::POS_QE];
      next_r.nf_ie = bus_i.wdata[txq_pkg::POS_NF];
      if (bus_i.wdata[txq_pkg::POS_SEND])
      begin
        next_r.send_req = 1'b1;
      end
      else if (r.send_req)
      begin
        // clearing a pending request asks the engine to abort
        next_r.send_req = 1'b0;
        next_r.abort_req = 1'b1;
      end
      do_inc = bus_i.wdata[txq_pkg::POS_INC] && not_full;
      if (bus_i.wdata[txq_pkg::POS_RESET])
      begin
        next_r.st = txq_pkg::ST_FLUSH;
      end
    end
    if (wr_treq && bus_i.wdata[0])
    begin
      // the mirror can only set the request, never abort
      next_r.send_req = 1'b1;
    end

    // engine events
    do_done = evt_i.done && !empty;
    if (do_inc)
    begin
      next_r.head = wrap_inc(r.head, r.depth_sel);
    end
    if (do_done)
    begin
      next_r.tail = wrap_inc(r.tail, r.depth_sel);
      next_r.aborted = 1'b0;
      next_r.arb_lost = 1'b0;
      next_r.bus_err = 1'b0;
    end
    next_r.count = r.count + {5'h00, do_inc} - {5'h00, do_done};
    if (do_done && (r.count == 6'h01) && !do_inc)
    begin
      next_r.send_req = 1'b0;
    end
    if (evt_i.abort_done)
    begin
      next_r.aborted = 1'b1;
      next_r.abort_req = 1'b0;
    end
    if (evt_i.arb_lost)
    begin
      next_r.arb_lost = 1'b1;
    end
    if (evt_i.bus_error)
    begin
      next_r.bus_err = 1'b1;
    end
    // software clears by writing zero; a same-cycle set wins
    if (wr_sta && !bus_i.wdata[txq_pkg::POS_AE])
    begin
      next_r.ae_flag = 1'b0;
    end
    if (evt_i.exhausted)
    begin
      next_r.ae_flag = 1'b1;
    end

    // queue flush takes one cycle, then the reset bit drops
    unique case (r.st)
      txq_pkg::ST_IDLE:
      begin
      end
      txq_pkg::ST_FLUSH:
      begin
        next_r.st = txq_pkg::ST_IDLE;
        next_r.head = 5'h00;
        next_r.tail = 5'h00;
        next_r.count = 6'h00;
        next_r.send_req = 1'b0;
        next_r.abort_req = 1'b0;
        next_r.aborted = 1'b0;
        next_r.arb_lost = 1'b0;
        next_r.bus_err = 1'b0;
      end
      default:
      begin
        next_r.st = txq_pkg::ST_IDLE;
      end
    endcase

    // read mux; unimplemented bits stay zero
    rd_mux = 16'h0000;
    unique case (bus_i.addr)
      txq_pkg::ADDR_BASE_LOW:
      begin
        rd_mux = {r.base, 2'h0};
      end
      txq_pkg::ADDR_CONFIG_HIGH:
      begin
        rd_mux = {r.payload_size_sel, r.depth_sel, 1'b0, r.retry_sel, r.prio};
      end
      txq_pkg::ADDR_CONTROL_LOW:
      begin
        rd_mux[txq_pkg::POS_RESET] = (r.st == txq_pkg::ST_FLUSH);
        rd_mux[txq_pkg::POS_SEND] = r.send_req;
        rd_mux[txq_pkg::POS_AE] = r.ae_ie;
        rd_mux[txq_pkg::POS_QE] = r.qe_ie;
        rd_mux[txq_pkg::POS_NF] = r.nf_ie;
      end
      txq_pkg::ADDR_STATUS:
      begin
        rd_mux[txq_pkg::POS_INDEX +: 5] = r.tail;
        rd_mux[txq_pkg::POS_ABORTED] = r.aborted;
        rd_mux[txq_pkg::POS_ARB] = r.arb_lost;
        rd_mux[txq_pkg::POS_BUSERR] = r.bus_err;
        rd_mux[txq_pkg::POS_AE] = r.ae_flag;
        rd_mux[txq_pkg::POS_QE] = empty;
        rd_mux[txq_pkg::POS_NF] = not_full;
      end
      txq_pkg::ADDR_IRQ_SUMMARY:
      begin
        rd_mux[0] = r.irq;
      end
      txq_pkg::ADDR_TX_REQUEST:
      begin
        rd_mux[0] = r.send_req;
      end
      txq_pkg::ADDR_GLOBAL_CTRL:
      begin
        rd_mux = {12'h000, r.retry_en, r.mode};
      end
      default:
      begin
        rd_mux = 16'h0000;
      end
    endcase
    next_r.rdata = bus_i.rd ? rd_mux : 16'h0000;

    // registered outputs, derived from the updated state
    next_r.irq = (next_r.ae_flag && next_r.ae_ie)
      || ((next_r.count == 6'h00) && next_r.qe_ie)
      || ((next_r.count < depth_of(next_r.depth_sel)) && next_r.nf_ie);
    next_r.ctrl.start = next_r.send_req && (next_r.count != 6'h00);
    next_r.ctrl.abort = next_r.abort_req;
    next_r.ctrl.index = next_r.tail;
    next_r.ctrl.priority_lvl = next_r.prio;
    next_r.ctrl.payload_bytes = payload_bytes(next_r.payload_size_sel);
    next_r.ctrl.retry_mode = retry_mode(next_r.retry_en, next_r.retry_sel);
    next_r.ctrl.base = {next_r.base, 2'h0};
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      r <= '0;
      r.st <= txq_pkg::ST_IDLE;
      r.retry_sel <= txq_pkg::RETRY_RESET;
      r.mode <= txq_pkg::MODE_RESET;
      r.irq <= 1'b0;
      r.ctrl.payload_bytes <= 7'h08;
      r.ctrl.retry_mode <= txq_pkg::RETRY_UNLIMITED;
    end
    else
    begin
      r <= next_r;
    end
  end

  // depth capacity: count reaches 32, so a 6-bit counter is needed
  assign rdata_o = r.rdata;
  assign ctrl_o = r.ctrl;
  assign irq_o = r.irq;

endmodule

// ### bench/txq_chk.sv
// port checker of the transmit queue control block
// assumes it is bound onto the block, one clock domain
`timescale 1ns/10ps
module txq_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // block ports
  input wire txq_pkg::bus_req_t bus_i,
  input wire logic [15:0] rdata_o,
  input wire txq_pkg::engine_evt_t evt_i,
  input wire txq_pkg::tx_ctrl_t ctrl_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  AST_BASE_ALIGN: assert property (ctrl_o.base[1:0] == 2'h0)
    else $error("base not word aligned");
  AST_BASE_READ: assert property (bus_i.rd && bus_i.addr == 3'h0 |=> rdata_o[1:0] == 2'h0)
    else $error("base low bits read set");
  AST_PAYLOAD: assert property (ctrl_o.payload_bytes inside
    {7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40})
    else $error("payload size not a legal value");
  AST_RETRY: assert property (ctrl_o.retry_mode != 2'h3)
    else $error("retry mode code 3 driven");
  AST_READ_PULSE: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0000)
    else $error("read data outside read answer cycle");
  AST_UNMAPPED: assert property (bus_i.rd && bus_i.addr == 3'h7 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_CONFIG_RSVD: assert property (bus_i.rd && bus_i.addr == 3'h1 |=> !rdata_o[7])
    else $error("config reserved bit set");
  AST_CTRL_RSVD: assert property (bus_i.rd && bus_i.addr == 3'h2 |=>
    (rdata_o & 16'hF9EA) == 16'h0000)
    else $error("control reserved bits set");
  AST_STATUS_RSVD: assert property (bus_i.rd && bus_i.addr == 3'h3 |=>
    (rdata_o & 16'hE00A) == 16'h0000)
    else $error("status reserved bits set");
  AST_ABORT_REQ: assert property (bus_i.wr && bus_i.addr == 3'h2 && !bus_i.wdata[9] &&
    !bus_i.wdata[10] && ctrl_o.start && !evt_i.done && !$past(evt_i.done)
    |-> ##[1:2] ctrl_o.abort)
    else $error("abort not raised");
  AST_ABORT_END: assert property (evt_i.abort_done && ctrl_o.abort |-> ##[1:2] !ctrl_o.abort)
    else $error("abort not dropped");
endmodule

bind can_fd_transmit_queue_control txq_chk chk (.clk_i(clk_i), .reset_i(reset_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .evt_i(evt_i), .ctrl_o(ctrl_o), .irq_o(irq_o));

// ### bench/txq_engine_model.sv
// protocol engine stand-in: answers each send with one event
// assumes the bench picks the outcome and the latency
`timescale 1ns/10ps
module txq_engine_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // block side
  input wire txq_pkg::tx_ctrl_t ctrl_i,
  output txq_pkg::engine_evt_t evt_o,
  // outcome and latency from the bench
  input wire logic [1:0] fault_i,
  input wire logic [3:0] delay_i
);
  logic [4:0] cnt;

  // three idle cycles after each event let the registered start fall
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      evt_o <= '0;
      cnt <= 5'h00;
    end
    else
    begin
      evt_o <= '0;
      if (cnt == 5'h00 && (ctrl_i.start || ctrl_i.abort))
        cnt <= {1'b0, delay_i} + 5'h04;
      else if (cnt != 5'h00)
        cnt <= cnt - 5'h01;
      if (cnt == 5'h04)
      begin
        evt_o.abort_done <= ctrl_i.abort;
        evt_o.done <= !ctrl_i.abort && fault_i == 2'h0;
        evt_o.arb_lost <= !ctrl_i.abort && fault_i == 2'h1;
        evt_o.bus_error <= !ctrl_i.abort && fault_i == 2'h2;
        evt_o.exhausted <= !ctrl_i.abort && fault_i == 2'h3;
      end
    end
  end
endmodule

// ### bench/can_fd_transmit_queue_control_bench.sv
// self-checking bench of the transmit queue control block
// assumes the package, design, checker and engine model are compiled
`timescale 1ns/10ps
module can_fd_transmit_queue_control_bench;
  logic clk_i;
  logic reset_i;
  txq_pkg::bus_req_t bus;
  logic [15:0] rdata;
  txq_pkg::engine_evt_t evt;
  txq_pkg::tx_ctrl_t ctrl;
  logic irq;
  logic [1:0] fault;
  logic [3:0] delay;
  int num_errors;
  int checked;
  logic [15:0] d;
  logic [15:0] r;
  localparam logic [15:0] RV [8] = '{16'h0000, 16'h0060, 16'h0000, 16'h0005,
    16'h0000, 16'h0000, 16'h0004, 16'h0000};

  can_fd_transmit_queue_control DUT (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus),
    .rdata_o(rdata), .evt_i(evt), .ctrl_o(ctrl), .irq_o(irq));
  txq_engine_model ENG (.clk_i(clk_i), .reset_i(reset_i), .ctrl_i(ctrl), .evt_o(evt),
    .fault_i(fault), .delay_i(delay));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----
  // expectations and bus tasks
  // ----
  function automatic logic [6:0] pay(input logic [2:0] c);
    case (c)
      3'h5: pay = 7'h20;
      3'h6: pay = 7'h30;
      3'h7: pay = 7'h40;
      default: pay = 7'h08 + {2'h0, c, 2'h0};
    endcase
  endfunction

  function automatic logic [1:0] rmode(input logic en, input logic [1:0] c);
    return (en && c < 2'h2) ? c : 2'h2;
  endfunction

  task automatic conclude();
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk_i);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask

  task automatic rc(input logic [2:0] a, input logic [15:0] e, input string nm);
    rd(a);
    cmp(nm, e, d);
  endtask

  // irq is registered, so two edges pass before it is looked at
  task automatic ci(input logic e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cmp("irq", {15'h0, e}, {15'h0, irq});
  endtask

  task automatic poll(input logic [15:0] m, input logic [15:0] v);
    int n;
    n = 0;
    rd(3'h3);
    while ((d & m) !== v && n < 80)
    begin
      rd(3'h3);
      n++;
    end
    if (n == 80)
    begin
      $display("MISMATCH status wait expected %h seen %h", v, d & m);
      num_errors++;
      conclude();
    end
  endtask

  initial
  begin
    #2000000;
    $display("MISMATCH run time expected end seen hang");
    num_errors++;
    conclude();
  end

  initial
  begin
    reset_i = 1'b1;
    bus = '0;
    fault = 2'h0;
    delay = 4'h1;
    num_errors = 0;
    checked = 0;
    void'($urandom(67));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++)
      rc(i[2:0], RV[i], "reset value");
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 0) ? 16'hFFFF : 16'($urandom);
      wr(3'h0, r);
      rc(3'h0, r & 16'hFFFC, "base");
      cmp("base out", r & 16'hFFFC, ctrl.base);
    end
    wr(3'h6, 16'h000C);
    for (int i = 0; i < 8; i++)
    begin
      r = {i[2:0], 5'($urandom), 1'b0, i[1:0], 5'($urandom)};
      wr(3'h1, r);
      rc(3'h1, r, "config");
      cmp("payload", {9'h0, pay(i[2:0])}, {9'h0, ctrl.payload_bytes});
      cmp("retry", {14'h0, rmode(1'b1, i[1:0])}, {14'h0, ctrl.retry_mode});
      cmp("priority", {11'h0, r[4:0]}, {11'h0, ctrl.priority_lvl});
    end
    wr(3'h1, 16'h0200);
    wr(3'h6, 16'h0004);
    rd(3'h1);
    cmp("retry", {14'h0, rmode(1'b0, 2'h0)}, {14'h0, ctrl.retry_mode});
    wr(3'h6, 16'h0000);
    wr(3'h1, 16'hE07F);
    rc(3'h1, 16'h027F, "locked");
    wr(3'h2, 16'h0100);
    rc(3'h3, 16'h0001, "one queued");
    repeat (3) wr(3'h2, 16'h0100);
    rc(3'h3, 16'h0000, "full");
    wr(3'h2, 16'h0005);
    ci(1'b0);
    rc(3'h4, 16'h0000, "summary");
    delay <= 4'($urandom_range(6, 1));
    wr(3'h2, 16'h0205);
    poll(16'h0004, 16'h0004);
    rc(3'h2, 16'h0005, "send cleared");
    cmp("start out", 16'h0000, {15'h0, ctrl.start});
    rc(3'h5, 16'h0000, "mirror");
    rc(3'h3, 16'h0005, "drained");
    cmp("index out", 16'h0000, {11'h0, ctrl.index});
    ci(1'b1);
    wr(3'h2, 16'h0100);
    fault <= 2'h1;
    wr(3'h5, 16'h0001);
    poll(16'h0040, 16'h0040);
    fault <= 2'h2;
    poll(16'h0020, 16'h0020);
    fault <= 2'h0;
    poll(16'h0004, 16'h0004);
    rc(3'h3, 16'h0105, "after retry");
    cmp("index out", 16'h0001, {11'h0, ctrl.index});
    fault <= 2'h3;
    wr(3'h2, 16'h0100);
    wr(3'h2, 16'h0210);
    poll(16'h0010, 16'h0010);
    ci(1'b1);
    wr(3'h2, 16'h0000);
    poll(16'h0080, 16'h0080);
    cmp("abort out", 16'h0000, {15'h0, ctrl.abort});
    ci(1'b0);
    fault <= 2'h0;
    rd(3'h3);
    cmp("exhausted held", 16'h0010, d & 16'h0010);
    wr(3'h3, 16'h0000);
    rd(3'h3);
    cmp("exhausted clear", 16'h0000, d & 16'h0010);
    wr(3'h2, 16'h0400);
    rd(3'h2);
    cmp("reset bit", 16'h0000, d & 16'h0400);
    rc(3'h3, 16'h0005, "after reset");
    wr(3'h2, 16'h0100);
    wr(3'h2, 16'h0004);
    ci(1'b0);
    wr(3'h2, 16'h0001);
    ci(1'b1);
    conclude();
  end
endmodule
